// ==== rtl/preq_defines.svh ====
// constants for the pipelined request enqueue block
// assumes inclusion by bare name from rtl/
`ifndef PREQ_DEFINES_SVH
`define PREQ_DEFINES_SVH
`define PREQ_ST_W 3
`define PREQ_ST_START 3'h7
`define PREQ_ST_IDLE 3'h7
`define PREQ_ST_RD_LO 3'h0
`define PREQ_ST_RD_HI 3'h1
`define PREQ_ST_WR_LO 3'h2
`define PREQ_ST_WR_HI 3'h3
`define PREQ_CBE_ZERO 4'h0
`define PREQ_LEN_LSB 0
`define PREQ_LEN_MSB 2
`define PREQ_ADDR_LSB 3
`define PREQ_START_WINDOW 2
`endif

// ==== rtl/preq_pkg.sv ====
// types for the pipelined request enqueue block
// assumes nothing beyond the defines header
package preq_pkg;
  typedef enum logic [2:0] {
    PREQ_IDLE = 3'b001,
    PREQ_GRANTED = 3'b010,
    PREQ_ENQUEUE = 3'b100
  } preq_state_type;
endpackage

// ==== rtl/preq_sync.sv ====
// two-flop synchroniser for pins entering the bus clock domain
// assumes a single clock and synchronous active low reset
`timescale 1ns/10ps
module preq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] dout_d;
  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      dout <= dout_d;
    end
  end
endmodule

// ==== rtl/preq_arbiter.sv ====
// What this block does
// - during read data return target drives command lanes to zero
// - lock and parity lines are unused on this port
// - interrupts level sensitive, shareable; lines a and b only
// - master raises request; arbiter grants with start status code
// - each strobe clock enqueues address, length and command
// - arbiter drops grant the clock after seeing strobe or frame
// - no wait states; target accepts a request every strobe clock
//
// core logic side arbiter and request queue feed for one graphics master
// assumes bus pins arrive asynchronously and the core owns a memory queue
`timescale 1ns/10ps
`include "preq_defines.svh"
module preq_arbiter import preq_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int SLOTS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_n,
  input wire logic pipe_n,
  input wire logic frame_n,
  input wire logic [ADDR_W-1:0] ad_in,
  input wire logic [3:0] command_byte_enable_lanes_in,
  input wire logic start_req,
  input wire logic rd_return,
  input wire logic rd_hi_prio,
  input wire logic slot_free,
  input wire logic [1:0] func_irq,
  output logic gnt_n,
  output logic [`PREQ_ST_W-1:0] grant_status_code,
  output logic [3:0] command_byte_enable_lanes_out,
  output logic command_byte_enable_lanes_oe,
  output logic lock_oe,
  output logic parity_line_oe,
  output logic interrupt_line_a_oe,
  output logic interrupt_line_b_oe,
  output logic enq_valid,
  output logic [ADDR_W-1:0] enq_addr,
  output logic [`PREQ_LEN_MSB:0] enq_len,
  output logic [3:0] enq_cmd,
  output logic [$clog2(SLOTS+1)-1:0] slots_used,
  output logic overflow
);
  logic req_s_n;
  logic pipe_s_n;
  logic frame_s_n;
  logic [ADDR_W-1:0] ad_s;
  logic [3:0] cbe_s;
  logic [1:0] irq_s;
  localparam int CW = $clog2(SLOTS+1);
  // pins cross through two flops; wide buses share the delay so they stay aligned
  preq_sync #(.W(3), .RESET_VAL(3'h7)) u_ctl (
    .clk(clk), .rst_n(rst_n),
    .din({req_n, pipe_n, frame_n}),
    .dout({req_s_n, pipe_s_n, frame_s_n})
  );
  preq_sync #(.W(ADDR_W + 6), .RESET_VAL('0)) u_dat (
    .clk(clk), .rst_n(rst_n),
    .din({ad_in, command_byte_enable_lanes_in, func_irq}),
    .dout({ad_s, cbe_s, irq_s})
  );
  preq_state_type state_q, state_d;
  logic gnt_n_d;
  logic [`PREQ_ST_W-1:0] st_d;
  logic [3:0] cbe_out_d;
  logic cbe_oe_d;
  logic enq_valid_d;
  logic [ADDR_W-1:0] enq_addr_d;
  logic [`PREQ_LEN_MSB:0] enq_len_d;
  logic [3:0] enq_cmd_d;
  logic [CW-1:0] used_d;
  logic overflow_d;
  logic irq_a_d;
  logic irq_b_d;
  function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] v, input logic inc,
                                            input logic dec);
    logic [CW-1:0] r;
    r = v;
    if (inc && !dec && v != CW'(SLOTS)) r = v + CW'(1);
    if (dec && !inc && v != '0) r = v - CW'(1);
    return r;
  endfunction
  function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a);
    // requests are 8 byte aligned; the low bits carry the length instead
    return {a[ADDR_W-1:`PREQ_ADDR_LSB], {`PREQ_ADDR_LSB{1'b0}}};
  endfunction
  function automatic logic strobe_in(input logic p_n, input preq_state_type s);
    // a strobe only counts while the master holds or has just held the grant
    return !p_n && (s != PREQ_IDLE);
  endfunction
  // grant state and the lanes parked during read return
  always_comb begin
    state_d = state_q;
    gnt_n_d = gnt_n;
    st_d = grant_status_code;
    cbe_out_d = `PREQ_CBE_ZERO;
    cbe_oe_d = 1'b0;
    unique case (state_q)
      PREQ_IDLE: begin
        gnt_n_d = 1'b1;
        st_d = `PREQ_ST_IDLE;
        if (rd_return) begin
          // read data grant; lanes parked at zero, master ignores them
          gnt_n_d = 1'b0;
          st_d = rd_hi_prio ? `PREQ_ST_RD_HI : `PREQ_ST_RD_LO;
          cbe_oe_d = 1'b1;
        end else if (!req_s_n && start_req) begin
          gnt_n_d = 1'b0;
          st_d = `PREQ_ST_START;
          state_d = PREQ_GRANTED;
        end
      end
      PREQ_GRANTED: begin
        if (!pipe_s_n || !frame_s_n) begin
          gnt_n_d = 1'b1;
          st_d = `PREQ_ST_IDLE;
          state_d = frame_s_n ? PREQ_ENQUEUE : PREQ_IDLE;
        end
      end
      PREQ_ENQUEUE: begin
        if (pipe_s_n) state_d = PREQ_IDLE;
      end
      default: state_d = PREQ_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PREQ_IDLE;
      gnt_n <= 1'b1;
      grant_status_code <= `PREQ_ST_IDLE;
      command_byte_enable_lanes_out <= `PREQ_CBE_ZERO;
      command_byte_enable_lanes_oe <= 1'b0;
    end else begin
      state_q <= state_d;
      gnt_n <= gnt_n_d;
      grant_status_code <= st_d;
      command_byte_enable_lanes_out <= cbe_out_d;
      command_byte_enable_lanes_oe <= cbe_oe_d;
    end
  end
  // request capture
  always_comb begin
    enq_valid_d = 1'b0;
    enq_addr_d = enq_addr;
    enq_len_d = enq_len;
    enq_cmd_d = enq_cmd;
    // every strobe clock takes a request, never stalled
    if (strobe_in(pipe_s_n, state_q)) begin
      enq_valid_d = 1'b1;
      enq_addr_d = align_addr(ad_s);
      enq_len_d = ad_s[`PREQ_LEN_MSB:`PREQ_LEN_LSB];
      enq_cmd_d = cbe_s;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enq_valid <= 1'b0;
      enq_addr <= '0;
      enq_len <= '0;
      enq_cmd <= 4'h0;
    end else begin
      enq_valid <= enq_valid_d;
      enq_addr <= enq_addr_d;
      enq_len <= enq_len_d;
      enq_cmd <= enq_cmd_d;
    end
  end
  // slot occupancy; the count saturates so a run of overruns cannot wrap it
  always_comb begin
    overflow_d = overflow;
    // the target cannot refuse, so an overrun is only flagged
    if (strobe_in(pipe_s_n, state_q) && slots_used == CW'(SLOTS) && !slot_free) begin
      overflow_d = 1'b1;
    end
    used_d = sat_add(slots_used, strobe_in(pipe_s_n, state_q), slot_free);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slots_used <= '0;
      overflow <= 1'b0;
    end else begin
      slots_used <= used_d;
      overflow <= overflow_d;
    end
  end
  logic lock_d;
  logic parity_d;
  // port pins: lock and parity stay released, interrupts are open drain
  always_comb begin
    lock_d = 1'b0; // never driven on this port
    parity_d = 1'b0;
    irq_a_d = irq_s[0] | irq_s[1];
    irq_b_d = 1'b0;
    // single function uses line a; a second function moves to line b
    if (irq_s[1]) begin
      irq_a_d = irq_s[0];
      irq_b_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_oe <= 1'b0;
      parity_line_oe <= 1'b0;
      interrupt_line_a_oe <= 1'b0;
      interrupt_line_b_oe <= 1'b0;
    end else begin
      lock_oe <= lock_d;
      parity_line_oe <= parity_d;
      interrupt_line_a_oe <= irq_a_d;
      interrupt_line_b_oe <= irq_b_d;
    end
  end
endmodule

// ==== verif/preq_asserts.sv ====
// port assertions for the enqueue arbiter
// assumes a bind onto preq_arbiter, one clock
`timescale 1ns/10ps
module preq_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pipe_n,
  input wire logic rd_return,
  input wire logic gnt_n,
  input wire logic [2:0] grant_status_code,
  input wire logic lock_oe,
  input wire logic parity_line_oe,
  input wire logic enq_valid,
  input wire logic [31:0] enq_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // four samples cover the pin synchroniser plus the output register
  sequence s_strobe; !pipe_n [*4]; endsequence
  sequence s_quiet; pipe_n [*4]; endsequence
  sequence s_pipe2; !pipe_n ##1 !pipe_n; endsequence
  a_pins_unused: assert property (!lock_oe && !parity_line_oe) else $error("lock");
  a_grant_drop: assert property (s_strobe |-> gnt_n) else $error("grant held");
  a_enq_ungranted: assert property (enq_valid |-> gnt_n) else $error("grant");
  a_addr_align: assert property (enq_valid |-> enq_addr[2:0] == 3'h0) else $error("addr");
  a_no_wait: assert property (s_pipe2 ##1 enq_valid |=> enq_valid) else $error("gap");
  a_no_strobe: assert property (s_quiet |-> !enq_valid) else $error("stray");
  a_start_code: assert property (
    $fell(gnt_n) && !$past(rd_return) && !$past(rd_return, 2) |-> grant_status_code == 3'h7)
    else $error("start code");
  a_grant_codes: assert property (
    !gnt_n |-> grant_status_code inside {3'h7, 3'h0, 3'h1}) else $error("code");
endmodule

// ==== verif/preq_master_model.sv ====
// master model: requests the bus, enqueues a burst on the strobe
// assumes the bench pulses go with length n and start delay dly
`timescale 1ns/10ps
module preq_master_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] n,
  input wire logic dly,
  input wire logic fr,
  input wire logic gnt_n,
  input wire logic [2:0] grant_status_code,
  output logic req_n,
  output logic pipe_n,
  output logic frame_n,
  output logic [31:0] ad,
  output logic [3:0] cbe
);
  logic [3:0] cmd;
  logic wr_be = 1'b0;
  int since_rd = 9;
  // lanes carry byte enables while write data moves; this arbiter never asks
  assign cbe = wr_be ? 4'hF : cmd;
  always @(posedge clk) begin
    wr_be <= gnt_n === 1'b0 && grant_status_code[2:1] === 2'b01;
    since_rd <= (gnt_n === 1'b0 && grant_status_code[2:1] === 2'b00) ? 0 : since_rd + 1;
  end
  // strobe method or one frame clock: sideband, lock and parity never move
  initial begin
    req_n = 1'b1;
    pipe_n = 1'b1;
    frame_n = 1'b1;
    ad = 32'h0;
    cmd = 4'h0;
  end
  always begin
    @(posedge clk iff go);
    #1 req_n = 1'b0;
    do @(posedge clk); while (gnt_n !== 1'b0 || grant_status_code !== 3'h7);
    while (since_rd < 2) @(posedge clk); // turnaround after read data only
    repeat (dly) @(posedge clk);
    if (fr) begin
      // a conventional cycle: one frame clock, nothing queued
      #1 frame_n = 1'b0;
      req_n = 1'b1;
      @(posedge clk);
      #1 frame_n = 1'b1;
    end else begin
      for (int i = 0; i < n; i++) begin
        #1 pipe_n = 1'b0;
        ad = {29'h200 + 29'(i), 3'(i)};
        cmd = 4'h6;
        req_n = (i == n - 1);
        @(posedge clk);
      end
      #1 pipe_n = 1'b1;
      ad = ~ad; // inverted so a stale value never passes
      cmd = ~cmd;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// bench: master model drives the arbiter, checker bound beside it
// assumes rtl and verif modules compiled first
`timescale 1ns/10ps
bind preq_arbiter preq_asserts u_chk (.clk, .rst_n, .pipe_n, .rd_return, .gnt_n,
  .grant_status_code, .lock_oe, .parity_line_oe, .enq_valid, .enq_addr);
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, dly = 1'b0, rd_return = 1'b0, slot_free = 1'b0;
  logic req_n, pipe_n, gnt_n, enq_valid, overflow, irq_a, irq_b;
  logic hp = 1'b0, start_ok = 1'b1, fr = 1'b0, frame_n, cbe_oe;
  logic [3:0] cbe_out;
  logic [4:0] b;
  logic [1:0] func_irq = 2'h0;
  logic [2:0] st, enq_len, slots, s;
  logic [3:0] n = 4'h1, cbe, enq_cmd;
  logic [31:0] ad, enq_addr;
  int num_errors, checks, got, cyc;
  preq_arbiter #(.SLOTS(4)) uut (.clk, .rst_n, .req_n, .pipe_n, .frame_n, .ad_in(ad),
    .command_byte_enable_lanes_in(cbe), .start_req(start_ok), .rd_return, .rd_hi_prio(hp),
    .slot_free, .func_irq, .gnt_n, .grant_status_code(st), .command_byte_enable_lanes_out(cbe_out),
    .command_byte_enable_lanes_oe(cbe_oe), .lock_oe(), .parity_line_oe(), .interrupt_line_a_oe(irq_a),
    .interrupt_line_b_oe(irq_b), .enq_valid, .enq_addr, .enq_len, .enq_cmd, .slots_used(slots),
    .overflow);
  preq_master_model m (.clk, .go, .n, .dly, .fr, .gnt_n, .grant_status_code(st), .req_n,
    .pipe_n, .frame_n, .ad, .cbe);
  initial forever #5 clk = ~clk;
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // outputs are judged mid-cycle, well clear of the edge that launches them
  always @(negedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      end_of_test;
    end
    if (enq_valid === 1'b1) begin
      chk("enq", {32'h1000 + 32'(got * 8), 3'(got), 4'h6}, {enq_addr, enq_len, enq_cmd});
      got++;
    end
  end
  task t_burst(input logic [3:0] c, input logic d);
    got = 0;
    n = c;
    dly = d;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (c + 12) @(posedge clk);
    #1 chk("count", c, got);
    $display("burst done");
  endtask
  task t_held;
    got = 0;
    n = 4'h1;
    start_ok = 1'b0;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("held gnt", 1, gnt_n);
    start_ok = 1'b1;
    repeat (12) @(posedge clk);
    #1 chk("held count", 1, got);
    $display("held done");
  endtask
  task t_frame;
    got = 0;
    fr = 1'b1;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (12) @(posedge clk);
    #1 chk("frame count", 0, got);
    chk("frame gnt", 1, gnt_n);
    fr = 1'b0;
    $display("frame done");
  endtask
  task t_read(input logic h);
    s = 3'h5;
    b = 5'h0F;
    hp = h;
    rd_return = 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1 rd_return = 1'b0;
      if (gnt_n === 1'b0) begin
        s = st;
        b = {cbe_oe, cbe_out};
      end
    end
    chk("read code", {2'b00, h}, s);
    chk("read lanes", 5'h10, b);
    $display("read done");
  endtask
  task t_reset;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("reset state", {1'b1, 3'h7, 3'h0, 1'b0}, {gnt_n, st, slots, overflow});
    $display("reset done");
  endtask
  task t_irq(input logic [1:0] v);
    func_irq = v;
    repeat (5) @(posedge clk);
    #1 chk("irq", v, {irq_b, irq_a});
    $display("irq done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 t_burst(4'h1, 1'b0);
    chk("slots", 1, slots);
    slot_free = 1'b1;
    @(posedge clk);
    #1 slot_free = 1'b0;
    t_burst(4'h5, 1'b1);
    chk("overflow", 1, overflow);
    t_held;
    t_frame;
    t_read(1'b0);
    t_read(1'b1);
    t_reset;
    for (int v = 0; v < 4; v++) t_irq(2'(v));
    end_of_test;
  end
endmodule
